// ### pkg/art_defs.svh
// constants of the auto-reload timer: register indices, fields, resets
`ifndef ART_DEFS_SVH
`define ART_DEFS_SVH
// register indices; the byte address is four times the index
`define ART_IDX_DUTY3 8'h73
`define ART_IDX_DUTY2 8'h74
`define ART_IDX_DUTY1 8'h75
`define ART_IDX_DUTY0 8'h76
`define ART_IDX_PWM_OUTPUT_CONTROL 8'h77
`define ART_IDX_CSR 8'h78
`define ART_IDX_CAR 8'h79
`define ART_IDX_ARR 8'h7A
`define ART_IDX_ICCSR 8'h7B
`define ART_IDX_ICR1 8'h7C
`define ART_IDX_ICR2 8'h7D
`define ART_IDX_IRQ_STAT 8'h7E
`define ART_IDX_IRQ_MASK 8'h7F
// field positions
`define ART_CSR_FORCE_BIT 2
`define ART_ICCSR_EDGE_LSB 4
`define ART_ICCSR_IE_LSB 2
`define ART_ICCSR_FLAG_LSB 0
// reset values and counter limits
`define ART_RESET_BYTE 8'h00
`define ART_RESET_WORD 32'h00000000
`define ART_CNT_MAX 8'hFF
`define ART_ICCSR_CTRL_MASK 8'h3C
`define ART_CSR_WR_MASK 8'hFA
`define ART_PRESC_ALL 7'h7F
`endif

// ### pkg/art_pkg.sv
// types shared by the auto-reload timer design files
package art_pkg;
    // timer control/status byte
    typedef struct packed {
        logic ext_clock_select;
        logic [2:0] prescale_select;
        logic counter_run;
        logic force_reload;
        logic overflow_irq_enable;
        logic overflow_flag;
    } art_csr_t;
    // capture control/status byte
    typedef struct packed {
        logic [1:0] unused;
        logic [1:0] edge_rising;
        logic [1:0] capture_irq_enable;
        logic [1:0] capture_flag;
    } art_iccsr_t;
    // pwm output control byte
    typedef struct packed {
        logic [3:0] out_enable;
        logic [3:0] pwm_out_polarity;
    } art_pwm_output_control_t;
    // decoded register selection
    typedef enum logic [3:0] {
        art_reg_duty3, art_reg_duty2, art_reg_duty1, art_reg_duty0,
        art_reg_pwm_output_control, art_reg_csr, art_reg_car, art_reg_arr,
        art_reg_iccsr, art_reg_icr1, art_reg_icr2,
        art_reg_irq_stat, art_reg_irq_mask, art_reg_none
    } art_reg_t;
endpackage

// ### rtl/art_prescaler.sv
// power-of-two prescaler forming the counter clock enable
`include "art_defs.svh"
module art_prescaler (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic tick_in,
    input wire logic run,
    input wire logic clear,
    input wire logic [2:0] prescale_select,
    // counter enable pulse
    output logic cnt_tick
);
    logic [6:0] div_cnt;
    logic [6:0] next_div_cnt;
    logic next_cnt_tick;
    logic [6:0] mask;

    // divide by 1..128; a frozen prescaler holds its count
    always_comb begin
        mask = `ART_PRESC_ALL >> (3'd7 - prescale_select);
        next_div_cnt = div_cnt;
        next_cnt_tick = 1'b0;
        if (clear) begin
            next_div_cnt = 7'h00;
        end else if (run && tick_in) begin
            next_div_cnt = 7'(div_cnt + 7'h01);
            next_cnt_tick = ((div_cnt & mask) == mask);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 7'h00;
            cnt_tick <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            cnt_tick <= next_cnt_tick;
        end
    end
endmodule

// ### rtl/art_capture_chan.sv
// one input capture channel: synchroniser, edge detect, latch and flag
`include "art_defs.svh"
module art_capture_chan (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // capture pin and controls
    input wire logic cap_pin,
    input wire logic edge_rising,
    input wire logic [7:0] count,
    input wire logic read_clear,
    // results
    output logic capture_flag,
    output logic [7:0] captured_count,
    output logic took
);
    logic sync1;
    logic sync2;
    logic prev;
    logic primed;
    logic edge_seen;
    logic take;
    logic next_flag;
    logic [7:0] next_value;

    // edge select; primed blocks only the first cycle after reset, so an idle-high pin still shows one rising edge
    always_comb begin
        edge_seen = edge_rising ? (sync2 && !prev) : (!sync2 && prev);
        // blocked while flagged, unless this very read frees it
        take = primed && edge_seen && (!capture_flag || read_clear);
        next_flag = capture_flag;
        next_value = captured_count;
        if (take) begin
            next_flag = 1'b1;
            next_value = count;
        end else if (read_clear) begin
            next_flag = 1'b0;
        end
    end

    // sync1 is read only by sync2
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev <= 1'b0;
            primed <= 1'b0;
            capture_flag <= 1'b0;
            captured_count <= `ART_RESET_BYTE;
            took <= 1'b0;
        end else begin
            sync1 <= cap_pin;
            sync2 <= sync1;
            prev <= sync2;
            primed <= 1'b1;
            capture_flag <= next_flag;
            captured_count <= next_value;
            took <= take;
        end
    end
endmodule

// ### rtl/art_timer.sv
// 8-bit auto-reload pwm timer with two input captures, apb register slave
// Summary of operation
// - bits 7:6 of capture control/status always read as zero.
// - per-channel edge select in bits 5:4; 0 falling, 1 rising.
// - per-channel capture interrupt enable in bits 3:2.
// - capture flag bits 1:0 set on capture, cleared by reading capture value.
// - capture value registers are read-only and hold the captured count.
// - eleven registers at consecutive indices 73h to 7Dh; the design adds irq status and mask at 7Eh and 7Fh.
// - reset clears capture control/status and both capture values.
// - rollover past FFh reloads counter and sets overflow flag, read clears.
// - a flagged channel takes no new capture until its value is read.
// - capture request stays high while flag and enable are both set.
// - three-bit prescale select divides input clock by 1 up to 128.
//
// The APB interface to the registers is this design's own decision.
`include "art_defs.svh"
module art_timer (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // apb answer
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timer pins
    input wire logic ext_clk_pin,
    input wire logic [1:0] cap_pin,
    output logic [3:0] pwm_out,
    output logic [3:0] pwm_oe,
    // interrupt requests
    output logic irq,
    output logic [1:0] capture_irq_req,
    output logic overflow_irq_req
);
    // register state
    logic [3:0][7:0] duty_value;
    art_pkg::art_pwm_output_control_t pwm_ctrl;
    art_pkg::art_csr_t csr;
    logic [7:0] reload_value;
    logic [1:0] edge_rising;
    logic [1:0] capture_irq_enable;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [7:0] counter;
    logic [3:0][7:0] compare;
    logic [2:0] rd_seen;
    // next values
    logic [3:0][7:0] next_duty_value;
    art_pkg::art_pwm_output_control_t next_pwm_ctrl;
    art_pkg::art_csr_t next_csr;
    logic [7:0] next_reload_value;
    logic [1:0] next_edge_rising;
    logic [1:0] next_capture_irq_enable;
    logic [2:0] next_irq_status;
    logic [2:0] next_irq_mask;
    logic [7:0] next_counter;
    logic [3:0][7:0] next_compare;
    logic [2:0] next_rd_seen;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [3:0] next_pwm_out;
    // decode and strobes
    art_pkg::art_reg_t reg_sel;
    logic [7:0] idx;
    logic [7:0] rd_byte;
    logic acc_done;
    logic wr_en;
    logic rd_en;
    logic [7:0] wbyte;
    logic force_reload;
    logic ovf_event;
    logic [1:0] cap_clear;
    // capture channel results
    logic [1:0] capture_flag;
    logic [7:0] captured_count [2];
    logic [1:0] cap_took;
    // external clock sampling
    logic ext_sync1;
    logic ext_sync2;
    logic ext_prev;
    logic cnt_tick;
    logic tick_in;

    // address decode; unaligned or unknown words answer with an error
    always_comb begin
        idx = paddr[9:2];
        if (paddr[1:0] != 2'b00 || paddr[11:10] != 2'b00) begin
            reg_sel = art_pkg::art_reg_none;
        end else if (idx == `ART_IDX_DUTY3) begin
            reg_sel = art_pkg::art_reg_duty3;
        end else if (idx == `ART_IDX_DUTY2) begin
            reg_sel = art_pkg::art_reg_duty2;
        end else if (idx == `ART_IDX_DUTY1) begin
            reg_sel = art_pkg::art_reg_duty1;
        end else if (idx == `ART_IDX_DUTY0) begin
            reg_sel = art_pkg::art_reg_duty0;
        end else if (idx == `ART_IDX_PWM_OUTPUT_CONTROL) begin
            reg_sel = art_pkg::art_reg_pwm_output_control;
        end else if (idx == `ART_IDX_CSR) begin
            reg_sel = art_pkg::art_reg_csr;
        end else if (idx == `ART_IDX_CAR) begin
            reg_sel = art_pkg::art_reg_car;
        end else if (idx == `ART_IDX_ARR) begin
            reg_sel = art_pkg::art_reg_arr;
        end else if (idx == `ART_IDX_ICCSR) begin
            reg_sel = art_pkg::art_reg_iccsr;
        end else if (idx == `ART_IDX_ICR1) begin
            reg_sel = art_pkg::art_reg_icr1;
        end else if (idx == `ART_IDX_ICR2) begin
            reg_sel = art_pkg::art_reg_icr2;
        end else if (idx == `ART_IDX_IRQ_STAT) begin
            reg_sel = art_pkg::art_reg_irq_stat;
        end else if (idx == `ART_IDX_IRQ_MASK) begin
            reg_sel = art_pkg::art_reg_irq_mask;
        end else begin
            reg_sel = art_pkg::art_reg_none;
        end
    end

    // read mux; write-only and reserved bits read as zero
    always_comb begin
        case (reg_sel)
            art_pkg::art_reg_duty3: rd_byte = duty_value[3];
            art_pkg::art_reg_duty2: rd_byte = duty_value[2];
            art_pkg::art_reg_duty1: rd_byte = duty_value[1];
            art_pkg::art_reg_duty0: rd_byte = duty_value[0];
            art_pkg::art_reg_pwm_output_control: rd_byte = pwm_ctrl;
            art_pkg::art_reg_csr: rd_byte = csr;
            art_pkg::art_reg_car: rd_byte = counter;
            art_pkg::art_reg_arr: rd_byte = reload_value;
            art_pkg::art_reg_iccsr: rd_byte = {2'b00, edge_rising,
                capture_irq_enable, capture_flag};
            art_pkg::art_reg_icr1: rd_byte = captured_count[0];
            art_pkg::art_reg_icr2: rd_byte = captured_count[1];
            art_pkg::art_reg_irq_stat: rd_byte = {5'h00, irq_status};
            art_pkg::art_reg_irq_mask: rd_byte = {5'h00, irq_mask};
            default: rd_byte = `ART_RESET_BYTE;
        endcase
    end

    // apb answer: one wait state so prdata comes from a flop
    always_comb begin
        acc_done = psel && penable && pready;
        wr_en = acc_done && pwrite && !pslverr;
        rd_en = acc_done && !pwrite && !pslverr;
        wbyte = pwdata[7:0];
        next_pready = psel && penable && !pready;
        next_prdata = prdata;
        next_pslverr = 1'b0;
        next_rd_seen = rd_seen;
        if (next_pready) begin
            next_pslverr = (reg_sel == art_pkg::art_reg_none);
            next_prdata = pwrite ? `ART_RESET_WORD : {24'h000000, rd_byte};
            // remember which flags this read actually showed
            next_rd_seen = {capture_flag, csr.overflow_flag};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `ART_RESET_WORD;
            pready <= 1'b0;
            pslverr <= 1'b0;
            rd_seen <= 3'b000;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            rd_seen <= next_rd_seen;
        end
    end

    // software-written control registers
    always_comb begin
        next_duty_value = duty_value;
        next_pwm_ctrl = pwm_ctrl;
        next_reload_value = reload_value;
        next_edge_rising = edge_rising;
        next_capture_irq_enable = capture_irq_enable;
        next_irq_mask = irq_mask;
        next_csr = csr;
        next_csr.force_reload = 1'b0;
        force_reload = 1'b0;
        if (wr_en) begin
            case (reg_sel)
                art_pkg::art_reg_duty3: next_duty_value[3] = wbyte;
                art_pkg::art_reg_duty2: next_duty_value[2] = wbyte;
                art_pkg::art_reg_duty1: next_duty_value[1] = wbyte;
                art_pkg::art_reg_duty0: next_duty_value[0] = wbyte;
                art_pkg::art_reg_pwm_output_control: next_pwm_ctrl = wbyte;
                art_pkg::art_reg_arr: next_reload_value = wbyte;
                art_pkg::art_reg_irq_mask: next_irq_mask = wbyte[2:0];
                art_pkg::art_reg_csr: begin
                    // overflow flag is hardware-owned; force bit is a pulse
                    next_csr = (wbyte & `ART_CSR_WR_MASK) |
                        {7'h00, csr.overflow_flag};
                    force_reload = wbyte[`ART_CSR_FORCE_BIT];
                end
                art_pkg::art_reg_iccsr: begin
                    // capture flags ignore writes
                    next_edge_rising =
                        wbyte[`ART_ICCSR_EDGE_LSB +: 2];
                    next_capture_irq_enable =
                        wbyte[`ART_ICCSR_IE_LSB +: 2];
                end
                default: ;
            endcase
        end
        // set wins over the clear-on-read in the same cycle
        if (ovf_event) begin
            next_csr.overflow_flag = 1'b1;
        end else if (rd_en && reg_sel == art_pkg::art_reg_csr &&
                     rd_seen[0]) begin
            next_csr.overflow_flag = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_value <= '0;
            pwm_ctrl <= '0;
            csr <= '0;
            reload_value <= `ART_RESET_BYTE;
            edge_rising <= 2'b00;
            capture_irq_enable <= 2'b00;
            irq_mask <= 3'b000;
        end else begin
            duty_value <= next_duty_value;
            pwm_ctrl <= next_pwm_ctrl;
            csr <= next_csr;
            reload_value <= next_reload_value;
            edge_rising <= next_edge_rising;
            capture_irq_enable <= next_capture_irq_enable;
            irq_mask <= next_irq_mask;
        end
    end

    // external clock: ext_sync1 feeds ext_sync2 only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_sync1 <= 1'b0;
            ext_sync2 <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_sync1 <= ext_clk_pin;
            ext_sync2 <= ext_sync1;
            ext_prev <= ext_sync2;
        end
    end

    // input clock is the bus clock or a rising external edge
    assign tick_in = csr.ext_clock_select ? (ext_sync2 && !ext_prev) : 1'b1;

    art_prescaler u_presc (
        .pclk(pclk),
        .presetn(presetn),
        .tick_in(tick_in),
        .run(csr.counter_run),
        .clear(force_reload),
        .prescale_select(csr.prescale_select),
        .cnt_tick(cnt_tick)
    );

    // counter: direct write, forced reload, then counting with rollover
    always_comb begin
        next_counter = counter;
        next_compare = compare;
        ovf_event = 1'b0;
        if (wr_en && reg_sel == art_pkg::art_reg_car) begin
            next_counter = wbyte;
        end else if (force_reload) begin
            next_counter = reload_value;
            next_compare = duty_value;
        end else if (cnt_tick && csr.counter_run) begin
            if (counter == `ART_CNT_MAX) begin
                next_counter = reload_value;
                ovf_event = 1'b1;
                // duty takes effect at a period edge to avoid glitches
                next_compare = duty_value;
            end else begin
                next_counter = 8'(counter + 8'h01);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter <= `ART_RESET_BYTE;
            compare <= '0;
        end else begin
            counter <= next_counter;
            compare <= next_compare;
        end
    end

    // a channel flag clears only if the read showed it set
    assign cap_clear[0] = rd_en && reg_sel == art_pkg::art_reg_icr1 &&
        rd_seen[1];
    assign cap_clear[1] = rd_en && reg_sel == art_pkg::art_reg_icr2 &&
        rd_seen[2];

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_cap
            art_capture_chan u_cap (
                .pclk(pclk),
                .presetn(presetn),
                .cap_pin(cap_pin[ch]),
                .edge_rising(edge_rising[ch]),
                .count(counter),
                .read_clear(cap_clear[ch]),
                .capture_flag(capture_flag[ch]),
                .captured_count(captured_count[ch]),
                .took(cap_took[ch])
            );
        end
    endgenerate

    // sticky event status, read clears; an event in that cycle survives
    always_comb begin
        next_irq_status = irq_status;
        if (rd_en && reg_sel == art_pkg::art_reg_irq_stat) begin
            next_irq_status = irq_status & ~prdata[2:0];
        end
        next_irq_status = next_irq_status | {cap_took, ovf_event};
    end

    // pwm level: high up to the compare value, flipped by polarity
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            next_pwm_out[i] = (counter <= compare[i]) ^
                pwm_ctrl.pwm_out_polarity[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 3'b000;
            irq <= 1'b0;
            capture_irq_req <= 2'b00;
            overflow_irq_req <= 1'b0;
            pwm_out <= 4'h0;
            pwm_oe <= 4'h0;
        end else begin
            irq_status <= next_irq_status;
            irq <= |(next_irq_status & irq_mask);
            capture_irq_req <= capture_flag & capture_irq_enable;
            overflow_irq_req <= csr.overflow_flag & csr.overflow_irq_enable;
            pwm_out <= next_pwm_out;
            pwm_oe <= pwm_ctrl.out_enable;
        end
    end
endmodule

// ### tb/art_timer_assertions.sv
// concurrent checks on the apb and capture ports of the timer
`include "art_defs.svh"
module art_timer_assertions (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // capture pins and requests
    input wire logic [1:0] cap_pin,
    input wire logic [1:0] capture_irq_req,
    input wire logic overflow_irq_req
);
    localparam logic [11:0] A_CSR = {2'b00, `ART_IDX_CSR, 2'b00};
    localparam logic [11:0] A_ICCSR = {2'b00, `ART_IDX_ICCSR, 2'b00};
    localparam logic [11:0] A_ICR1 = {2'b00, `ART_IDX_ICR1, 2'b00};
    logic done;
    logic clr1;
    logic wr_cc;
    logic csr_acc;
    // completing transfers, the only edges where side effects land
    assign done = psel && penable && pready;
    assign clr1 = done && !pwrite && paddr == A_ICR1;
    assign wr_cc = done && pwrite && paddr == A_ICCSR;
    assign csr_acc = done && paddr == A_CSR;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_ONE_WAIT: assert property (psel && penable && !$past(penable)
        |-> !pready ##1 pready) else $error("pready not after one wait");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_UPPER_ZERO: assert property (pready |->
        prdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    AST_RSVD_ZERO: assert property (done && !pwrite && paddr == A_ICCSR
        |-> prdata[7:6] == 2'b00) else $error("reserved bits read as one");
    AST_ERR_MAP: assert property (done |-> pslverr ==
        (paddr[1:0] != 2'b00 || paddr[11:10] != 2'b00 ||
        paddr[9:2] < `ART_IDX_DUTY3 || paddr[9:2] > `ART_IDX_IRQ_MASK))
        else $error("error response does not match address map");
    // the request may only drop one or two edges after a clearing read or a rewrite
    AST_CAP_HOLD: assert property (capture_irq_req[0] && !clr1 &&
        !$past(clr1) && !wr_cc && !$past(wr_cc) |=> capture_irq_req[0])
        else $error("capture request dropped without a read");
    AST_OVF_HOLD: assert property (overflow_irq_req && !csr_acc &&
        !$past(csr_acc) |=> overflow_irq_req)
        else $error("overflow request dropped without a read");
    AST_CAP_LATENCY: assert property ($rose(capture_irq_req[0]) |->
        $past(cap_pin[0], 4) != $past(cap_pin[0], 5) || $past(wr_cc, 2))
        else $error("capture request rose at the wrong time");
endmodule

bind art_timer art_timer_assertions u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cap_pin(cap_pin),
    .capture_irq_req(capture_irq_req), .overflow_irq_req(overflow_irq_req));

// ### tb/art_pin_model.sv
// capture pin source standing in for the outside world
module art_pin_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pin levels requested by the bench
    input wire logic [1:0] want,
    // pins toward the timer
    output logic [1:0] cap_pin,
    output logic ext_clk_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // pins idle high as if pulled up and move only after a clock edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_pin <= 2'b11;
        end else begin
            cap_pin <= want;
        end
    end
    // external clock is never selected here, so it stays low
    assign ext_clk_pin = 1'b0;
endmodule

// ### tb/art_timer_test.sv
// self-checking bench for the auto-reload timer register slave
`include "art_defs.svh"
module art_timer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic irq, overflow_irq_req, ext_clk_pin;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] cap_pin, want, capture_irq_req;
    logic [3:0] pwm_out, pwm_oe;
    int fails, n_checks;
    art_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_clk_pin(ext_clk_pin), .cap_pin(cap_pin), .pwm_out(pwm_out),
        .pwm_oe(pwm_oe), .irq(irq), .capture_irq_req(capture_irq_req),
        .overflow_irq_req(overflow_irq_req));
    art_pin_model i_pins (.pclk(pclk), .presetn(presetn), .want(want),
        .cap_pin(cap_pin), .ext_clk_pin(ext_clk_pin));
    // value comparison
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer; the request holds until pready is sampled high
    task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr8(input logic [7:0] idx, input logic [7:0] v);
        apb(1'b1, idx, v);
    endtask
    task rd8(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rd, {24'h000000, exp});
    endtask
    // bounded wait for the capture requests to reach a value
    task wait_req(input logic [1:0] exp);
        for (int i = 0; i < 20 && capture_irq_req !== exp; i++)
            @(posedge pclk);
        chk({30'h0, capture_irq_req}, {30'h0, exp});
    endtask
    task t_reset;
        for (int i = 32'h73; i <= 32'h7F; i++) rd8(8'(i), 8'h00);
        apb(1'b0, 8'h80, 8'h00);
        chk({31'h0, err}, 32'h1);
        $display("test reset_values done");
    endtask
    task t_access;
        wr8(`ART_IDX_DUTY3, 8'hA5);
        rd8(`ART_IDX_DUTY3, 8'hA5);
        wr8(`ART_IDX_ICR1, 8'hFF);
        rd8(`ART_IDX_ICR1, 8'h00);
        wr8(`ART_IDX_ICCSR, 8'hFF);
        rd8(`ART_IDX_ICCSR, 8'h3C);
        // outputs on, polarity 0101; counter and compare both still zero
        wr8(`ART_IDX_PWM_OUTPUT_CONTROL, 8'hF5);
        repeat (2) @(posedge pclk);
        chk({28'h0, pwm_oe}, 32'h0000000F);
        chk({28'h0, pwm_out}, 32'h0000000A);
        $display("test access done");
    endtask
    task t_capture;
        wr8(`ART_IDX_ICCSR, 8'h1C);
        wr8(`ART_IDX_IRQ_MASK, 8'h02);
        wr8(`ART_IDX_CAR, 8'h5A); // counter stopped, so the value is known
        want <= 2'b10;
        repeat (8) @(posedge pclk);
        chk({30'h0, capture_irq_req}, 32'h0);
        want <= 2'b11;
        wait_req(2'b01);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        rd8(`ART_IDX_ICCSR, 8'h1D);
        wr8(`ART_IDX_CAR, 8'h33);
        want <= 2'b10;
        repeat (4) @(posedge pclk);
        want <= 2'b11;
        repeat (8) @(posedge pclk);
        rd8(`ART_IDX_ICR1, 8'h5A);
        rd8(`ART_IDX_ICCSR, 8'h1C);
        rd8(`ART_IDX_IRQ_STAT, 8'h02);
        rd8(`ART_IDX_IRQ_STAT, 8'h00);
        chk({30'h0, capture_irq_req}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr8(`ART_IDX_IRQ_MASK, 8'h00);
        want <= 2'b01;
        wait_req(2'b10);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        rd8(`ART_IDX_ICR2, 8'h33);
        rd8(`ART_IDX_IRQ_STAT, 8'h04);
        $display("test capture done");
    endtask
    task t_overflow;
        wr8(`ART_IDX_ARR, 8'hF0);
        wr8(`ART_IDX_CAR, 8'hFE);
        wr8(`ART_IDX_CSR, 8'h0A);
        for (int i = 0; i < 40 && overflow_irq_req !== 1'b1; i++)
            @(posedge pclk);
        chk({31'h0, overflow_irq_req}, 32'h1);
        wr8(`ART_IDX_CSR, 8'h02); // stop; the flag is not writable
        rd8(`ART_IDX_CSR, 8'h03);
        rd8(`ART_IDX_CSR, 8'h02);
        rd8(`ART_IDX_IRQ_STAT, 8'h01);
        wr8(`ART_IDX_CSR, 8'h06);
        rd8(`ART_IDX_CAR, 8'hF0);
        rd8(`ART_IDX_CSR, 8'h02);
        // divide by 8 for about 20 cycles: two counts, a margin either side
        wr8(`ART_IDX_CSR, 8'h38);
        repeat (16) @(posedge pclk);
        wr8(`ART_IDX_CSR, 8'h30);
        rd8(`ART_IDX_CAR, 8'hF2);
        $display("test overflow done");
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // free-running 50 MHz clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // the whole run needs well under 2000 cycles
    initial begin
        #200us;
        fails++;
        $display("mismatch at %0t: got %h exp %h", $time, 1'b0, 1'b1);
        close_out;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        want = 2'b11;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_access;
        t_capture;
        t_overflow;
        close_out;
    end
endmodule
